// ---- rtl/pms_master.sv ----
// phy management serial master: register port, mdc divider and frame engine
//
// Function
// R01: test-reset bit in config holds the management engine in reset until cleared
// R02: mdc is divided from the system clock by config field bits 5:2
// R03: divisor codes 000x=4, 0010=6 up to 1000=40; others undefined
// R04: software keeps mdc at or below 2.5 MHz, 12.5 MHz only if tolerated
// R05: preamble-suppress bit drops the 32-bit preamble from every frame
// R06: sweep polling reads phy addresses 1 up to the phy field value
// R07: without sweep, polling reads always target the same phy address
// R08: command scan bit makes the engine issue reads back to back continuously
// R09: command read bit starts exactly one read whose data lands in read data
// R10: with read bit clear, a write frame carries the write-data register value
// R11: address bits 12:8 are the phy address of every frame except sweep polling reads
// R12: address bits 4:0 are the register address of every frame
// R13: 16- and 32-bit accesses work, aliases too; 8-bit accesses are ignored
// R14: unimplemented register bits read back as zero
// R15: each write to write data starts one write frame with held addresses; writes made while a write request is still pending share one frame
// R16: after a read frame the 16 received bits are readable in read data
// R17: busy shows a frame in progress, pending shows read data not yet valid
// R18: link-failure flag follows the last status value read from the phy
// R19: frames follow clause 22: preamble, start, op, addresses, turnaround, data
// R20: the phy address field resets to 1
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module pms_master (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_size,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe
);

  // half mdc period in system clocks for a divisor code
  function automatic logic [4:0] half_period(input logic [3:0] code);
    case (code)
      4'h0, 4'h1: half_period = 5'h02; // R03
      4'h2: half_period = 5'h03;
      4'h3: half_period = 5'h04;
      4'h4: half_period = 5'h05;
      4'h5: half_period = 5'h07;
      4'h6: half_period = 5'h0a;
      4'h7: half_period = 5'h0e;
      4'h8: half_period = 5'h14;
      default: half_period = 5'h14; // undefined codes run slowest, the safe choice
    endcase
  endfunction : half_period

  // register update through plain, clear, set and invert aliases
  function automatic logic [31:0] reg_update(input logic [31:0] old, input logic [31:0] wd,
      input logic [1:0] op, input logic [31:0] lanes, input logic [31:0] impl);
    logic [31:0] m;
    m = lanes & impl; // R14
    case (op)
      pms_pkg::AL_CLR: reg_update = old & ~(wd & m);
      pms_pkg::AL_SET: reg_update = old | (wd & m);
      pms_pkg::AL_INV: reg_update = old ^ (wd & m);
      default: reg_update = (old & ~m) | (wd & m);
    endcase
  endfunction : reg_update

  logic rst_meta_r, rst_sync_r;
  logic mdio_meta_r, mdio_sync_r;
  logic [31:0] cfg_r, cmd_r, adr_r, wtd_r;
  logic [31:0] cfg_nxt, cmd_nxt, adr_nxt, wtd_nxt;
  logic [31:0] lane_mask, rdata_nxt, rdata_r;
  logic [1:0] alias_op;
  logic hit_cfg, hit_cmd, hit_adr, hit_wtd;
  logic wr_cfg, wr_cmd, wr_adr, wr_wtd;
  logic eng_rst, start_rd, start_wr;
  logic rd_req_r, wr_req_r, scan_on;
  logic take_wr, take_rd, take_scan;
  pms_pkg::pms_state_t state_r;
  logic [63:0] shift_r, frame;
  logic [6:0] left_r;
  logic is_read_r, is_scan_r;
  logic [4:0] half_r, div_cnt_r, cur_phy_r, reg_sel_r, frame_phy;
  logic mdc_r, mdio_out_r, mdio_oe_r;
  logic tick, rise_tick, fall_tick;
  logic [15:0] shift_in_r, rdd_r;
  logic pending_r, link_fail_r, scan_ind_r;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else if (clk_en) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // mdio pin synchroniser; only the second flop is read
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mdio_meta_r <= 1'b1;
      mdio_sync_r <= 1'b1;
    end else if (clk_en) begin
      mdio_meta_r <= mdio_in;
      mdio_sync_r <= mdio_meta_r;
    end
  end

  // byte lanes: bytes ignored, upper half touches only unimplemented bits
  always_comb begin
    case (reg_size)
      pms_pkg::SZ_WORD: lane_mask = pms_pkg::LANE_WORD; // R13
      pms_pkg::SZ_HALF: lane_mask = reg_addr[1] ? 32'h0 : pms_pkg::LANE_HALF; // R13
      default: lane_mask = 32'h0; // R13
    endcase
  end

  // address decode, aliases live in the low nibble
  assign alias_op = reg_addr[3:2];
  assign hit_cfg = reg_addr[7:4] == pms_pkg::CFG_OFS[7:4];
  assign hit_cmd = reg_addr[7:4] == pms_pkg::CMD_OFS[7:4];
  assign hit_adr = reg_addr[7:4] == pms_pkg::ADR_OFS[7:4];
  assign hit_wtd = reg_addr[7:4] == pms_pkg::WTD_OFS[7:4];
  assign wr_cfg = reg_wr && hit_cfg && (|lane_mask);
  assign wr_cmd = reg_wr && hit_cmd && (|lane_mask);
  assign wr_adr = reg_wr && hit_adr && (|lane_mask);
  assign wr_wtd = reg_wr && hit_wtd && (|lane_mask);
  assign cfg_nxt = reg_update(cfg_r, reg_wdata, alias_op, lane_mask, pms_pkg::CFG_MASK);
  assign cmd_nxt = reg_update(cmd_r, reg_wdata, alias_op, lane_mask, pms_pkg::CMD_MASK);
  assign adr_nxt = reg_update(adr_r, reg_wdata, alias_op, lane_mask, pms_pkg::ADR_MASK);
  assign wtd_nxt = reg_update(wtd_r, reg_wdata, alias_op, lane_mask, pms_pkg::WTD_MASK);

  // software registers; config itself survives the test reset so it can be cleared
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cfg_r <= pms_pkg::CFG_RST;
      cmd_r <= pms_pkg::CMD_RST;
      adr_r <= pms_pkg::ADR_RST; // R20
      wtd_r <= pms_pkg::WTD_RST;
    end else if (clk_en) begin
      if (wr_cfg) cfg_r <= cfg_nxt;
      if (wr_cmd) cmd_r <= cmd_nxt;
      if (wr_adr) adr_r <= adr_nxt;
      if (wr_wtd) wtd_r <= wtd_nxt;
    end
  end

  assign eng_rst = cfg_r[pms_pkg::CFG_TRST_BIT]; // R01
  assign start_rd = wr_cmd && cmd_nxt[pms_pkg::CMD_READ_BIT]
                    && !cmd_r[pms_pkg::CMD_READ_BIT]; // R09
  assign start_wr = wr_wtd && lane_mask[0]; // R15
  assign scan_on = cmd_r[pms_pkg::CMD_SCAN_BIT]; // R08
  assign take_wr = (state_r == pms_pkg::ST_IDLE) && wr_req_r; // R10
  assign take_rd = (state_r == pms_pkg::ST_IDLE) && !wr_req_r && rd_req_r;
  assign take_scan = (state_r == pms_pkg::ST_IDLE) && !wr_req_r && !rd_req_r && scan_on;

  // pending requests; a new request in the take cycle is kept
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
    end else if (clk_en) begin
      if (eng_rst) begin
        rd_req_r <= 1'b0; // R01
        wr_req_r <= 1'b0;
      end else begin
        rd_req_r <= (rd_req_r && !take_rd) || start_rd;
        wr_req_r <= (wr_req_r && !take_wr) || start_wr;
      end
    end
  end

  // phy for the next frame: sweep only applies to polling reads
  assign frame_phy = (take_scan && cfg_r[pms_pkg::CFG_SWEEP_BIT]) ? cur_phy_r // R06
                     : adr_r[pms_pkg::ADR_PHY_LSB +: 5]; // R07 R11
  assign frame = {pms_pkg::PREAMBLE, pms_pkg::FR_START, // R19
                  take_wr ? pms_pkg::OP_WRITE : pms_pkg::OP_READ,
                  frame_phy, adr_r[pms_pkg::ADR_REG_LSB +: 5], // R12
                  take_wr ? pms_pkg::TA_WRITE : pms_pkg::TA_READ,
                  take_wr ? wtd_r[15:0] : 16'hffff}; // R10

  // mdc divider runs only during a frame, idle level low
  assign tick = (state_r == pms_pkg::ST_FRAME) && (div_cnt_r == half_r - 5'h01);
  assign rise_tick = tick && !mdc_r;
  assign fall_tick = tick && mdc_r;

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      div_cnt_r <= 5'h00;
      mdc_r <= 1'b0;
      half_r <= 5'h14;
    end else if (clk_en) begin
      if (eng_rst || state_r != pms_pkg::ST_FRAME) begin
        div_cnt_r <= 5'h00;
        mdc_r <= 1'b0;
        // latched at frame start so a mid-frame change cannot glitch mdc
        half_r <= half_period(cfg_r[pms_pkg::CFG_DIV_LSB +: 4]); // R02
      end else if (tick) begin
        div_cnt_r <= 5'h00;
        mdc_r <= !mdc_r; // R02
      end else begin
        div_cnt_r <= div_cnt_r + 5'h01;
      end
    end
  end

  // frame engine: bits change after mdc falls, phy samples on the rise
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= pms_pkg::ST_IDLE;
      shift_r <= 64'h0;
      left_r <= 7'h00;
      is_read_r <= 1'b0;
      is_scan_r <= 1'b0;
      reg_sel_r <= 5'h00;
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
    end else if (clk_en) begin
      if (eng_rst) begin
        state_r <= pms_pkg::ST_IDLE; // R01
        mdio_oe_r <= 1'b0;
        mdio_out_r <= 1'b0;
      end else begin
        case (state_r)
          pms_pkg::ST_IDLE: begin
            if (take_wr || take_rd || take_scan) begin
              state_r <= pms_pkg::ST_FRAME;
              is_read_r <= !take_wr;
              is_scan_r <= take_scan;
              reg_sel_r <= adr_r[pms_pkg::ADR_REG_LSB +: 5];
              mdio_oe_r <= 1'b1;
              if (cfg_r[pms_pkg::CFG_PREAMBLE_SUPPRESS_BIT]) begin
                shift_r <= {frame[31:0], 32'h0}; // R05
                left_r <= pms_pkg::LEN_PREAMBLE_SUPPRESS;
                mdio_out_r <= frame[31];
              end else begin
                shift_r <= frame; // R05
                left_r <= pms_pkg::LEN_FULL;
                mdio_out_r <= frame[63];
              end
            end
          end
          pms_pkg::ST_FRAME: begin
            if (fall_tick) begin
              if (left_r == 7'h01) begin
                state_r <= pms_pkg::ST_DONE;
                mdio_oe_r <= 1'b0;
                mdio_out_r <= 1'b0;
              end else begin
                shift_r <= {shift_r[62:0], 1'b0};
                left_r <= left_r - 7'h01;
                mdio_out_r <= shift_r[62];
                // read frames release the line from the turnaround on
                mdio_oe_r <= !is_read_r || (left_r - 7'h01 > pms_pkg::LEFT_TA); // R19
              end
            end
          end
          pms_pkg::ST_DONE: state_r <= pms_pkg::ST_IDLE;
          default: state_r <= pms_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // sample read data on each mdc rise in the data field
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      shift_in_r <= 16'h0;
    end else if (clk_en) begin
      if (rise_tick && is_read_r && left_r <= pms_pkg::LEFT_DATA) begin
        shift_in_r <= {shift_in_r[14:0], mdio_sync_r}; // R19
      end
    end
  end

  // read results, link flag and sweep address
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdd_r <= 16'h0;
      pending_r <= 1'b0;
      link_fail_r <= 1'b0;
      cur_phy_r <= pms_pkg::PHY_FIRST;
    end else if (clk_en) begin
      if (eng_rst) begin
        rdd_r <= 16'h0; // R01
        pending_r <= 1'b0;
        link_fail_r <= 1'b0;
        cur_phy_r <= pms_pkg::PHY_FIRST;
      end else begin
        if (state_r == pms_pkg::ST_DONE && is_read_r) begin
          rdd_r <= shift_in_r; // R16
          pending_r <= 1'b0; // R17
          if (reg_sel_r == pms_pkg::STATUS_REG) begin
            link_fail_r <= !shift_in_r[pms_pkg::LINK_UP_BIT]; // R18
          end
          if (is_scan_r) begin
            // wrap back to the first phy once the field value is reached
            cur_phy_r <= (cur_phy_r >= adr_r[pms_pkg::ADR_PHY_LSB +: 5])
                         ? pms_pkg::PHY_FIRST : cur_phy_r + 5'h01; // R06
          end
        end
        if (take_rd || take_scan) pending_r <= 1'b1; // R17
      end
    end
  end

  // scan indicator follows the command bit while the engine is enabled
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) scan_ind_r <= 1'b0;
    else if (clk_en) scan_ind_r <= scan_on && !eng_rst;
  end

  // read mux; unmapped offsets and byte reads return zero
  always_comb begin
    case (reg_addr[7:4])
      pms_pkg::CFG_OFS[7:4]: rdata_nxt = cfg_r;
      pms_pkg::CMD_OFS[7:4]: rdata_nxt = cmd_r;
      pms_pkg::ADR_OFS[7:4]: rdata_nxt = adr_r;
      pms_pkg::WTD_OFS[7:4]: rdata_nxt = wtd_r;
      pms_pkg::RDD_OFS[7:4]: rdata_nxt = {16'h0, rdd_r}; // R14
      pms_pkg::IND_OFS[7:4]: rdata_nxt = {28'h0, link_fail_r, pending_r, scan_ind_r,
                                          state_r != pms_pkg::ST_IDLE}; // R17
      default: rdata_nxt = 32'h0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) rdata_r <= 32'h0;
    else if (clk_en) rdata_r <= reg_rd ? (rdata_nxt & lane_mask) : 32'h0; // R13
  end

  assign reg_rdata = rdata_r;
  assign mdc = mdc_r;
  assign mdio_out = mdio_out_r;
  assign mdio_oe = mdio_oe_r;

endmodule : pms_master
`default_nettype wire

// ---- shared/pms_pkg.sv ----
// constants, register map and frame layout for the phy management serial master
package pms_pkg;
  // register byte offsets; each register owns a 16-byte slot holding its aliases
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h10;
  localparam logic [7:0] ADR_OFS = 8'h20;
  localparam logic [7:0] WTD_OFS = 8'h30;
  localparam logic [7:0] RDD_OFS = 8'h40;
  localparam logic [7:0] IND_OFS = 8'h50;
  // alias selector in address bits 3:2
  localparam logic [1:0] AL_PLAIN = 2'h0;
  localparam logic [1:0] AL_CLR = 2'h1;
  localparam logic [1:0] AL_SET = 2'h2;
  localparam logic [1:0] AL_INV = 2'h3;
  // access size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [31:0] LANE_WORD = 32'hffff_ffff;
  localparam logic [31:0] LANE_HALF = 32'h0000_ffff;
  // implemented bits and reset values
  localparam logic [31:0] CFG_MASK = 32'h0000_803f;
  localparam logic [31:0] CMD_MASK = 32'h0000_0003;
  localparam logic [31:0] ADR_MASK = 32'h0000_1f1f;
  localparam logic [31:0] WTD_MASK = 32'h0000_ffff;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] ADR_RST = 32'h0000_0100;
  localparam logic [31:0] WTD_RST = 32'h0000_0000;
  // field positions
  localparam int CFG_TRST_BIT = 15;
  localparam int CFG_DIV_LSB = 2;
  localparam int CFG_PREAMBLE_SUPPRESS_BIT = 1;
  localparam int CFG_SWEEP_BIT = 0;
  localparam int CMD_SCAN_BIT = 1;
  localparam int CMD_READ_BIT = 0;
  localparam int ADR_PHY_LSB = 8;
  localparam int ADR_REG_LSB = 0;
  // frame layout
  localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] FR_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_READ = 2'h3;
  localparam logic [6:0] LEN_FULL = 7'h40;
  localparam logic [6:0] LEN_PREAMBLE_SUPPRESS = 7'h20;
  localparam logic [6:0] LEFT_TA = 7'h12;
  localparam logic [6:0] LEFT_DATA = 7'h10;
  localparam logic [4:0] PHY_FIRST = 5'h01;
  localparam logic [4:0] STATUS_REG = 5'h01;
  localparam int LINK_UP_BIT = 2;
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FRAME = 3'b010,
    ST_DONE = 3'b100
  } pms_state_t;
endpackage : pms_pkg

// ---- verification/pms_chk.sv ----
// port assertions for the phy management serial master
`timescale 1ns/10ps
`default_nettype none
module pms_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_size,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // shortest half period is two system clocks
  sequence s_hi2;
    mdc [*2];
  endsequence
  sequence s_lo2;
    !mdc [*2];
  endsequence
  a_mdc_min_high: assert property ($rose(mdc) |-> s_hi2)
    else $error("mdc high phase too short");
  a_mdc_max_high: assert property ($rose(mdc) |-> ##[2:20] $fell(mdc))
    else $error("mdc high phase too long");
  a_frame_first_bit: assert property ($rose(mdio_oe) |-> s_lo2 ##[1:19] mdc)
    else $error("frame does not open with a low mdc phase");
  a_data_on_fall: assert property ($past(mdio_oe) && mdio_oe && $changed(mdio_out) |-> $fell(mdc))
    else $error("mdio changed away from a falling mdc");
  a_stable_while_high: assert property (mdc |-> $stable(mdio_out) && $stable(mdio_oe))
    else $error("mdio moved while mdc high");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_byte_read_ignored: assert property ($past(reg_rd) && ($past(reg_size) inside {2'h0, 2'h3})
    |-> reg_rdata == 32'h0)
    else $error("byte read returned data");
  a_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[31:16] == 16'h0)
    else $error("unimplemented upper bits set");
endmodule : pms_chk
bind pms_master pms_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_size(reg_size),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
`default_nettype wire

// ---- verification/pms_phy_model.sv ----
// behavioural phy on the management line: decodes frames, answers reads
`timescale 1ns/10ps
`default_nettype none
module pms_phy_model (
  input wire logic mdc,
  input wire logic pin,
  output logic drv_oe,
  output logic drv_out,
  output int n_frames,
  output int f_ones,
  output logic [1:0] f_op,
  output logic [9:0] f_adr,
  output logic [15:0] f_data
);
  logic [15:0] mem [0:1023];
  logic [15:0] rd;
  logic [15:0] sh;
  int cnt;
  int ones;
  initial begin
    drv_oe = 1'b0;
    drv_out = 1'b1;
    n_frames = 0;
    cnt = 0;
    ones = 0;
    for (int i = 0; i < 1024; i++) mem[i] = {10'(i), 6'h2a};
  end
  // bits taken on the rising edge; mdc stands still between frames
  always @(posedge mdc) begin
    if (cnt == 0) begin
      if (pin) ones++;
      else begin
        f_ones = ones;
        cnt = 1;
      end
    end else begin
      sh = {sh[14:0], pin};
      cnt++;
      if (cnt == 14) begin
        f_op = sh[11:10];
        f_adr = sh[9:0];
        rd = mem[sh[9:0]];
      end
      // second turnaround bit low, then data msb first
      if (f_op == 2'h2 && cnt >= 15 && cnt < 32) begin
        drv_oe = 1'b1;
        drv_out = (cnt == 15) ? 1'b0 : rd[31 - cnt];
      end
      if (cnt == 32) begin
        f_data = (f_op == 2'h2) ? rd : sh;
        if (f_op == 2'h1) mem[f_adr] = sh;
        n_frames++;
        cnt = 0;
        ones = 0;
      end
    end
  end
  // release after the last bit's hold; the pull-up takes the line
  always @(negedge mdc) if (cnt == 0) drv_oe = 1'b0;
endmodule : pms_phy_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the phy management serial master
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk, rst_n, clk_en, reg_wr, reg_rd, mdc, mdio_out, mdio_oe, drv_oe, drv_out;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q, seed;
  logic [1:0] reg_size, f_op;
  logic [9:0] f_adr, pa;
  logic [15:0] f_data, d;
  int n_frames, f_ones, n0, k, m_fail;
  int err_count = 0;
  int n_compared = 0;
  int mr [4] = '{0, 0, 'h100, 0};
  int mk [4] = '{'h803f, 3, 'h1f1f, 'hffff};
  int hv [9] = '{2, 2, 3, 4, 5, 7, 10, 14, 20};
  int pm [int];
  wire logic mdio_pin = mdio_oe ? mdio_out : (drv_oe ? drv_out : 1'b1);
  pms_master u_pms_master (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc), .mdio_in(mdio_pin),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  pms_phy_model u_pms_phy_model (.mdc(mdc), .pin(mdio_pin), .drv_oe(drv_oe),
    .drv_out(drv_out), .n_frames(n_frames), .f_ones(f_ones), .f_op(f_op), .f_adr(f_adr),
    .f_data(f_data));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected phy contents: what was written, else the power-up pattern
  function automatic logic [15:0] ev(input logic [9:0] a);
    return pm.exists(int'(a)) ? 16'(pm[int'(a)]) : {a, 6'h2a};
  endfunction : ev
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic close_out();
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // bus write, mirrored into the register model
  task automatic w(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] s = 2'h2);
    int i;
    i = a[7:4];
    if (i < 4 && (s == 2'h2 || (s == 2'h1 && !a[1]))) begin
      case (a[3:2])
        2'h0: mr[i] = dv & mk[i];
        2'h1: mr[i] &= ~(dv & mk[i]);
        2'h2: mr[i] |= dv & mk[i];
        default: mr[i] ^= dv & mk[i];
      endcase
    end
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_size <= s;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : w
  task automatic r(input logic [7:0] a, input logic [31:0] e, input string n,
    input logic [1:0] s = 2'h2, input logic [31:0] m = 32'hffff_ffff);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_size <= s;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, reg_rdata & m);
  endtask : r
  // bounded wait for the phy to see one more complete frame
  task automatic wf();
    n0 = n_frames;
    for (k = 0; k < 20000 && n_frames == n0; k++) @(negedge ref_clk);
    if (n_frames == n0) begin
      err_count++;
      close_out();
    end
  endtask : wf
  task automatic cf(input logic [1:0] op, input logic [9:0] ad, input logic [15:0] dv, input int o);
    chk("frame_op", op, f_op);
    chk("frame_addr", ad, f_adr);
    chk("frame_data", dv, f_data);
    chk("frame_preamble", o, f_ones);
  endtask : cf
  initial begin
    seed = 32'd41;
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_size = 2'h0;
    m_fail = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) r(8'(i * 16), 32'(mr[i]), "reset_value");
    r(pms_pkg::RDD_OFS, 32'h0, "rdd_reset");
    w(pms_pkg::ADR_OFS, 32'hffff_ffff);
    w(pms_pkg::CFG_OFS, 32'hffff_7fff);
    w(pms_pkg::ADR_OFS + 8'h4, 32'h0000_0f03);
    w(pms_pkg::ADR_OFS + 8'hc, 32'h0000_0101);
    w(pms_pkg::ADR_OFS, 32'h0, 2'h0);
    w(pms_pkg::ADR_OFS + 8'h8, 32'h4, 2'h1);
    w(pms_pkg::ADR_OFS + 8'h2, 32'h0, 2'h1);
    w(8'h60, 32'h1);
    for (int i = 0; i < 3; i += 2) r(8'(i * 16), 32'(mr[i]), "masked_value");
    r(pms_pkg::ADR_OFS + 8'h8, 32'(mr[2]), "alias_read");
    r(pms_pkg::CFG_OFS, 32'h0, "byte_read", 2'h0);
    r(8'h60, 32'h0, "unmapped");
    // every divider code; the fastest ones need a phy that tolerates them
    for (int c = 0; c < 16; c++) begin
      q = xs();
      pa = {q[12:8] | 5'h1, q[4:0]};
      pm[int'(pa)] = int'(q[15:0]);
      w(pms_pkg::CFG_OFS, 32'(c * 4 + 2));
      w(pms_pkg::ADR_OFS, {19'h0, pa[9:5], 3'h0, pa[4:0]});
      w(pms_pkg::WTD_OFS, q, 2'(c % 2 + 1));
      // the previous frame's last high phase can outlast the three writes
      for (k = 0; k < 30 && mdc; k++) @(negedge ref_clk);
      for (k = 0; k < 300 && !mdc; k++) @(negedge ref_clk);
      for (k = 0; k < 30 && mdc; k++) @(negedge ref_clk);
      chk("mdc_half", 32'(c < 9 ? hv[c] : 20), 32'(k));
      wf();
      cf(pms_pkg::OP_WRITE, pa, q[15:0], 0);
    end
    w(pms_pkg::CFG_OFS, 32'h0);
    pm[int'(pa)] = 'ha5c3;
    w(pms_pkg::WTD_OFS, 32'h0000_a5c3);
    wf();
    cf(pms_pkg::OP_WRITE, pa, 16'ha5c3, 32);
    // single reads of phy 3 register 1: link up, then link down
    for (int j = 0; j < 2; j++) begin
      d = j ? 16'hbeeb : 16'h1234;
      pm[int'(10'h061)] = int'(d);
      w(pms_pkg::ADR_OFS, 32'h0000_0301);
      w(pms_pkg::WTD_OFS, {16'h0, d});
      wf();
      w(pms_pkg::CMD_OFS, 32'h1);
      repeat (4) @(posedge ref_clk);
      r(pms_pkg::IND_OFS, {28'h0, m_fail[0], 3'h5}, "ind_busy");
      wf();
      cf(pms_pkg::OP_READ, 10'h061, ev(10'h061), 32);
      m_fail = !d[2];
      repeat (300) @(posedge ref_clk);
      chk("one_read", 32'(n0 + 1), 32'(n_frames));
      r(pms_pkg::RDD_OFS, {16'h0, d}, "read_data");
      r(pms_pkg::IND_OFS, {28'h0, m_fail[0], 3'h0}, "ind_done");
      w(pms_pkg::CMD_OFS, 32'h0);
    end
    // polling one phy without sweep
    w(pms_pkg::CFG_OFS, 32'h2);
    w(pms_pkg::ADR_OFS, 32'h0000_0501);
    w(pms_pkg::CMD_OFS, 32'h2);
    for (int j = 0; j < 3; j++) begin
      wf();
      cf(pms_pkg::OP_READ, 10'h0a1, ev(10'h0a1), 0);
    end
    r(pms_pkg::IND_OFS, 32'h2, "ind_scan", 2'h2, 32'h2);
    w(pms_pkg::CMD_OFS, 32'h0);
    repeat (300) @(posedge ref_clk);
    n0 = n_frames;
    repeat (300) @(posedge ref_clk);
    chk("scan_stopped", 32'(n0), 32'(n_frames));
    // test reset holds the engine, keeps the registers, drops the request
    w(pms_pkg::CFG_OFS, 32'h8002);
    w(pms_pkg::WTD_OFS, 32'h1);
    repeat (300) @(posedge ref_clk);
    r(pms_pkg::CFG_OFS, 32'h8002, "cfg_kept");
    r(pms_pkg::IND_OFS, 32'h0, "ind_held");
    // clk_en low freezes the registers: a write in that cycle is lost
    @(posedge ref_clk);
    clk_en <= 1'b0;
    w(pms_pkg::CFG_OFS, 32'h0);
    clk_en <= 1'b1;
    r(pms_pkg::CFG_OFS, 32'h8002, "cfg_frozen");
    w(pms_pkg::CFG_OFS, 32'h3);
    repeat (300) @(posedge ref_clk);
    chk("held_in_reset", 32'(n0), 32'(n_frames));
    // sweep polling over phys 1 to 3, wrapping back to 1
    w(pms_pkg::ADR_OFS, 32'h0000_0302);
    w(pms_pkg::CMD_OFS, 32'h2);
    for (int j = 0; j < 4; j++) begin
      pa = {5'(j % 3 + 1), 5'h2};
      wf();
      cf(pms_pkg::OP_READ, pa, ev(pa), 0);
    end
    w(pms_pkg::CMD_OFS, 32'h0);
    repeat (300) @(posedge ref_clk);
    close_out();
  end
endmodule : tb
`default_nettype wire
